// *** include/oad_pkg.sv ***
// address map, enable bits and timing constants of the on-chip address decoder
package oad_pkg;
  localparam int ADDR_W = 24;
  // flash sectors in user mode, then the test sector that bootstrap maps over the first 8K
  localparam logic [23:0] FLASH_LOW_BASE = 24'h00_0000;
  localparam logic [23:0] FLASH_LOW_LAST = 24'h00_7FFF;
  localparam logic [23:0] FLASH_S4_BASE  = 24'h01_8000;
  localparam logic [23:0] FLASH_S4_LAST  = 24'h01_FFFF;
  localparam logic [23:0] FLASH_S5_BASE  = 24'h02_0000;
  localparam logic [23:0] FLASH_S5_LAST  = 24'h02_FFFF;
  localparam logic [23:0] UPPER_A_BASE   = 24'h03_0000;
  localparam logic [23:0] UPPER_B_LAST   = 24'h04_FFFF;
  localparam logic [23:0] TEST_SEC_BASE  = 24'h00_0000;
  localparam logic [23:0] TEST_SEC_LAST  = 24'h00_1FFF;
  // peripheral-bus windows
  localparam logic [23:0] RAM1_BASE      = 24'h00_E000;
  localparam logic [23:0] RAM1_LAST      = 24'h00_E7FF;
  localparam logic [15:0] PAGE_CAN1      = 16'h00EF;
  localparam logic [15:0] PAGE_CAN2      = 16'h00EE;
  localparam logic [15:0] PAGE_RTC       = 16'h00ED;
  localparam logic [15:0] PAGE_PWM       = 16'h00EC;
  localparam logic [15:0] PAGE_ASC       = 16'h00E9;
  localparam logic [15:0] PAGE_SSC       = 16'h00E8;
  localparam logic [15:0] PAGE_I2C       = 16'h00EA;
  localparam logic [15:0] PAGE_MISC      = 16'h00EB;
  // second RAM default window and mirror span
  localparam logic [23:0] RAM2_RESET_BASE = 24'h09_0000;
  localparam int          RAM2_MIRROR_BYTES = 16384;
  localparam int          RAM2_SMALL_BYTES  = 8192;
  // enable bit positions
  localparam int SYS_GLOBAL_BIT = 2;
  localparam int EN_CAN1 = 0;
  localparam int EN_CAN2 = 1;
  localparam int EN_RAM1 = 2;
  localparam int EN_RAM2 = 3;
  localparam int EN_RTC  = 4;
  localparam int EN_PWM  = 6;
  localparam int EN_ASC  = 7;
  localparam int EN_SSC  = 8;
  localparam int EN_I2C  = 9;
  localparam int EN_MISC = 10;
  // segment lines available on the port
  localparam int SEG_LINES_FULL = 8;
  localparam int SEG_LINES_CAN  = 4;
  // timing: periph access time and cycles at the local clock
  localparam int CLK_PERIOD_PS   = 20000;
  localparam int PERIPH_WAIT_NUM = 2;
  localparam int PERIPH_ACC_PS   = 62500;
  localparam int RAM_ACC_PS      = 31250;
  localparam int PERIPH_ACC_CYC  =
    (PERIPH_ACC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RAM_ACC_CYC     = 1;
  // target codes, one-hot
  typedef enum logic [8:0] {
    TGT_EXT   = 9'h001,
    TGT_FLASH = 9'h002,
    TGT_TEST  = 9'h004,
    TGT_RAM1  = 9'h008,
    TGT_RAM2  = 9'h010,
    TGT_PERIPH = 9'h020,
    TGT_UPPER = 9'h040,
    TGT_PAD0  = 9'h080,
    TGT_PAD1  = 9'h100
  } oad_target_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } oad_state_t;
  // true when addr lies in [lo, hi]
  function automatic logic oad_in(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// *** hw/oad_periph_sel.sv ***
`timescale 1ns/10ps
// peripheral-bus page decode gated by global and per-module enables
module oad_periph_sel
  import oad_pkg::*;
(
  // address and enables
  input  wire logic [23:0] addr,
  input  wire logic        global_en,
  input  wire logic [15:0] periph_en,
  // result
  output logic [7:0]       sel
);
  logic [15:0] page;
  assign page = addr[23:8];
  // each page only exists when its enable and the global enable are set
  always_comb begin
    sel    = '0;
    sel[0] = global_en && periph_en[EN_CAN1] && (page == PAGE_CAN1);
    sel[1] = global_en && periph_en[EN_CAN2] && (page == PAGE_CAN2);
    sel[2] = global_en && periph_en[EN_RTC]  && (page == PAGE_RTC);
    sel[3] = global_en && periph_en[EN_PWM]  && (page == PAGE_PWM);
    sel[4] = global_en && periph_en[EN_ASC]  && (page == PAGE_ASC);
    sel[5] = global_en && periph_en[EN_SSC]  && (page == PAGE_SSC);
    sel[6] = global_en && periph_en[EN_I2C]  && (page == PAGE_I2C);
    sel[7] = global_en && periph_en[EN_MISC] && (page == PAGE_MISC);
  end
endmodule

// *** hw/oad_ram2_win.sv ***
`timescale 1ns/10ps
// second extension RAM window match with mirroring
module oad_ram2_win
  import oad_pkg::*;
#(
  parameter int RAM2_BYTES = RAM2_MIRROR_BYTES
)
(
  // address and window
  input  wire logic [23:0] addr,
  input  wire logic [23:0] win_base,
  input  wire logic        enabled,
  // result
  output logic             hit,
  output logic [13:0]      offset
);
  localparam int WIN_BITS = 16;
  // the mirror mask only serves the two array sizes the offset field holds
  if (RAM2_BYTES != RAM2_SMALL_BYTES && RAM2_BYTES != RAM2_MIRROR_BYTES) begin : g_bad_size
    $error("RAM2_BYTES must be 8192 or 16384");
  end
  // window is a 64K block; the array mirrors on each RAM2_BYTES boundary (8K or 16K)
  assign hit    = enabled && (addr[23:WIN_BITS] == win_base[23:WIN_BITS]);
  assign offset = addr[13:0] & 14'(RAM2_BYTES - 1);
endmodule

// *** hw/oad_decoder.sv ***
`timescale 1ns/10ps
// on-chip address decoder: routes cpu accesses to flash, ext ram, periph bus or ext bus
module oad_decoder
  import oad_pkg::*;
#(
  parameter int RAM2_BYTES  = RAM2_MIRROR_BYTES,
  parameter int PERIPH_WAIT = PERIPH_WAIT_NUM
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // configuration
  input  wire logic        periph_bus_global_enable,
  input  wire logic [15:0] periph_enable_register,
  input  wire logic        bootstrap_mode,
  input  wire logic        window_write,
  input  wire logic [7:0]  second_ram_window_select,
  // cpu request
  input  wire logic        req,
  input  wire logic [23:0] addr,
  input  wire logic        write,
  input  wire logic        byte_access,
  input  wire logic        bit_access,
  input  wire logic        stack_access,
  // routing answer
  output logic             ack,
  output logic             access_error,
  output logic [8:0]       target,
  output logic [7:0]       periph_select,
  output logic [13:0]      ram2_offset,
  output logic             ext_cycle,
  output logic [23:0]      ext_addr,
  output logic             ext_write,
  output logic             ext_byte,
  // status
  output logic [23:0]      ram2_window,
  output logic [3:0]       segment_lines
);
  // refuse a mirror size or wait count that the counters cannot serve
  if (RAM2_BYTES != RAM2_SMALL_BYTES && RAM2_BYTES != RAM2_MIRROR_BYTES) begin : g_bad_ram2
    $error("RAM2_BYTES must be 8192 or 16384");
  end
  if (PERIPH_WAIT < 1 || PERIPH_WAIT > 7) begin : g_bad_wait
    $error("PERIPH_WAIT out of range");
  end

  typedef struct packed {
    oad_state_t  state;
    logic [2:0]  wait_cnt;
    logic [7:0]  win;
    logic        ack;
    logic        err;
    logic [8:0]  target;
    logic [7:0]  psel;
    logic [13:0] roff;
    logic        ext;
    logic [23:0] eaddr;
    logic        ewr;
    logic        ebyte;
  } oad_regs_t;

  localparam logic [7:0] WIN_RESET = RAM2_RESET_BASE[23:16];

  oad_regs_t   r;
  oad_regs_t   next_r;
  logic [7:0]  psel_now;
  logic        ram2_hit;
  logic [13:0] ram2_off;
  logic        ram1_hit;
  logic        flash_hit;
  logic        test_hit;
  logic        upper_hit;
  logic        ram1_en;
  logic        ram2_en;

  assign ram1_en = periph_bus_global_enable && periph_enable_register[EN_RAM1];
  assign ram2_en = periph_bus_global_enable && periph_enable_register[EN_RAM2];
  assign ram1_hit = ram1_en && oad_in(addr, RAM1_BASE, RAM1_LAST);
  // bootstrap replaces the first flash 8K with the test sector
  assign test_hit  = bootstrap_mode && oad_in(addr, TEST_SEC_BASE, TEST_SEC_LAST);
  assign flash_hit = !test_hit && (oad_in(addr, FLASH_LOW_BASE, FLASH_LOW_LAST) ||
                     oad_in(addr, FLASH_S4_BASE, FLASH_S4_LAST) ||
                     oad_in(addr, FLASH_S5_BASE, FLASH_S5_LAST));
  // upper sectors still answer; hardware does not block them
  assign upper_hit = oad_in(addr, UPPER_A_BASE, UPPER_B_LAST);

  oad_periph_sel u_psel (
    .addr      (addr),
    .global_en (periph_bus_global_enable),
    .periph_en (periph_enable_register),
    .sel       (psel_now)
  );

  oad_ram2_win #(.RAM2_BYTES(RAM2_BYTES)) u_ram2 (
    .addr     (addr),
    .win_base ({r.win, 16'h0000}),
    .enabled  (ram2_en),
    .hit      (ram2_hit),
    .offset   (ram2_off)
  );

  // next-state: decode on request, hold periph access for its wait states
  always_comb begin
    next_r     = r;
    next_r.ack = 1'b0;
    next_r.err = 1'b0;
    if (window_write) begin
      next_r.win = second_ram_window_select;
    end
    unique case (r.state)
      ST_IDLE: begin
        if (req) begin
          next_r.ext    = 1'b0;
          next_r.psel   = '0;
          next_r.eaddr  = addr;
          next_r.ewr    = write;
          next_r.ebyte  = byte_access;
          next_r.roff   = '0;
          if (test_hit) begin
            next_r.target = TGT_TEST;
            next_r.ack    = 1'b1;
          end else if (flash_hit) begin
            next_r.target = TGT_FLASH;
            next_r.ack    = 1'b1;
          end else if (upper_hit) begin
            next_r.target = TGT_UPPER;
            next_r.ack    = 1'b1;
          end else if (ram1_hit || ram2_hit) begin
            // ext ram is bus-like: bit ops and stack use are refused
            next_r.target = ram1_hit ? TGT_RAM1 : TGT_RAM2;
            next_r.roff   = ram1_hit ? 14'(addr[10:0]) : ram2_off;
            next_r.err    = bit_access || stack_access;
            next_r.ack    = 1'b1;
          end else if (psel_now != '0) begin
            next_r.target = TGT_PERIPH;
            next_r.psel   = psel_now;
            if (byte_access || bit_access) begin
              next_r.err = 1'b1;
              next_r.ack = 1'b1;
            end else begin
              next_r.state    = ST_WAIT;
              next_r.wait_cnt = 3'(PERIPH_WAIT);
            end
          end else begin
            // disabled modules and unmapped space fall through
            next_r.target = TGT_EXT;
            next_r.ext    = 1'b1;
            next_r.ack    = 1'b1;
          end
        end else begin
          next_r.ext = 1'b0;
        end
      end
      ST_WAIT: begin
        if (r.wait_cnt == 3'd1) begin
          next_r.state = ST_DONE;
        end
        next_r.wait_cnt = r.wait_cnt - 3'd1;
      end
      ST_DONE: begin
        next_r.ack   = 1'b1;
        next_r.state = ST_IDLE;
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
  end

  // state register; a low clk_en freezes everything but reset
  always_ff @(posedge clk) begin
    if (reset) begin
      r        <= '0;
      r.state  <= ST_IDLE;
      r.target <= TGT_EXT;
      r.win    <= WIN_RESET;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign ack           = r.ack;
  assign access_error  = r.err;
  assign target        = r.target;
  assign periph_select = r.psel;
  assign ram2_offset   = r.roff;
  assign ext_cycle     = r.ext;
  assign ext_addr      = r.eaddr;
  assign ext_write     = r.ewr;
  assign ext_byte      = r.ebyte;
  assign ram2_window   = {r.win, 16'h0000};
  // CAN modules borrow half the segment pins
  assign segment_lines = (periph_bus_global_enable && (periph_enable_register[EN_CAN1] ||
                          periph_enable_register[EN_CAN2])) ? 4'(SEG_LINES_CAN)
                         : 4'(SEG_LINES_FULL);

  // checks: a request is taken only in idle with the clock enabled
  logic        take_now;
  logic [15:0] page_now;
  assign take_now = (r.state == ST_IDLE) && req && clk_en;
  assign page_now = addr[23:8];

  // reset and window
  a_reset_window: assert property (@(posedge clk)
    $rose(!reset) |-> ram2_window == RAM2_RESET_BASE)
    else $error("second ram window not at reset base");
  a_window_load: assert property (@(posedge clk) disable iff (reset)
    (window_write && clk_en) |=> ram2_window[23:16] == $past(second_ram_window_select))
    else $error("window select not loaded");
  a_ram2_gate: assert property (@(posedge clk) disable iff (reset)
    (take_now && !periph_bus_global_enable && addr[23:16] == r.win
     && !test_hit && !flash_hit && !upper_hit) |=> ext_cycle)
    else $error("second ram window not external while bus off");

  // memory map
  a_boot_test: assert property (@(posedge clk) disable iff (reset)
    (take_now && bootstrap_mode && addr == TEST_SEC_BASE) |=> target == TGT_TEST)
    else $error("test sector not visible in bootstrap");
  a_test_hidden: assert property (@(posedge clk) disable iff (reset)
    (take_now && !bootstrap_mode && addr == TEST_SEC_BASE) |=> target == TGT_FLASH)
    else $error("test sector visible in user mode");
  a_user_flash: assert property (@(posedge clk) disable iff (reset)
    (take_now && !bootstrap_mode && addr == FLASH_S4_BASE) |=> target == TGT_FLASH)
    else $error("flash sector not mapped");
  a_unmapped_ext: assert property (@(posedge clk) disable iff (reset)
    (take_now && !test_hit && !flash_hit && !upper_hit && !ram1_hit && !ram2_hit
     && psel_now == '0) |=> ack && ext_cycle && ext_addr == $past(addr))
    else $error("unmatched access not passed on");

  // extension ram: bus-like, zero wait, no bit or stack use
  a_ram1_gate: assert property (@(posedge clk) disable iff (reset)
    (take_now && !periph_bus_global_enable && oad_in(addr, RAM1_BASE, RAM1_LAST))
    |=> ack && ext_cycle && target == TGT_EXT)
    else $error("disabled first ram not external");
  a_ram_zero_wait: assert property (@(posedge clk) disable iff (reset)
    (take_now && !test_hit && !flash_hit && !upper_hit && !ram1_hit && ram2_hit)
    |=> ack && target == TGT_RAM2)
    else $error("second ram not zero wait");
  a_ram_byte_ok: assert property (@(posedge clk) disable iff (reset)
    (take_now && ram1_hit && byte_access && !bit_access && !stack_access)
    |=> ack && !access_error && target == TGT_RAM1)
    else $error("byte access to first ram refused");
  a_ram_bit_use: assert property (@(posedge clk) disable iff (reset)
    (take_now && ram1_hit && (bit_access || stack_access)) |=> ack && access_error)
    else $error("bit or stack use of ext ram allowed");

  // peripheral pages: each needs the global enable and its own bit
  a_can1_page: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && periph_enable_register[EN_CAN1]
     && page_now == PAGE_CAN1 && !ram2_hit) |=> periph_select == 8'h01)
    else $error("first can page not selected");
  a_can2_page: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && periph_enable_register[EN_CAN2]
     && page_now == PAGE_CAN2 && !ram2_hit) |=> periph_select == 8'h02)
    else $error("second can page not selected");
  a_rtc_page: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && periph_enable_register[EN_RTC]
     && page_now == PAGE_RTC && !ram2_hit) |=> periph_select == 8'h04)
    else $error("clock module page not selected");
  a_pwm_page: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && periph_enable_register[EN_PWM]
     && page_now == PAGE_PWM && !ram2_hit) |=> periph_select == 8'h08)
    else $error("pulse module page not selected");
  a_asc_page: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && periph_enable_register[EN_ASC]
     && page_now == PAGE_ASC && !ram2_hit) |=> periph_select == 8'h10)
    else $error("async serial page not selected");
  a_ssc_page: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && periph_enable_register[EN_SSC]
     && page_now == PAGE_SSC && !ram2_hit) |=> periph_select == 8'h20)
    else $error("sync serial page not selected");
  a_i2c_page: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && periph_enable_register[EN_I2C]
     && page_now == PAGE_I2C && !ram2_hit) |=> periph_select == 8'h40)
    else $error("i2c page not selected");
  a_misc_page: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && periph_enable_register[EN_MISC]
     && page_now == PAGE_MISC && !ram2_hit) |=> periph_select == 8'h80)
    else $error("misc feature page not selected");
  a_disabled_gone: assert property (@(posedge clk) disable iff (reset)
    (take_now && periph_bus_global_enable && !periph_enable_register[EN_CAN1]
     && page_now == PAGE_CAN1 && !ram2_hit) |=> ext_cycle && periph_select == 8'h00)
    else $error("disabled module still decoded");

  // peripheral timing and refusals; a frozen clock would stretch the wait
  a_periph_wait: assert property (@(posedge clk) disable iff (reset || !clk_en)
    (take_now && psel_now != '0 && !ram1_hit && !ram2_hit && !byte_access && !bit_access)
    |-> ##1 !ack [*3] ##1 ack)
    else $error("periph access acked at the wrong cycle");
  a_periph_byte: assert property (@(posedge clk) disable iff (reset)
    (take_now && psel_now != '0 && !ram1_hit && !ram2_hit && byte_access)
    |=> ack && access_error)
    else $error("byte access to periph not refused");
  a_err_with_ack: assert property (@(posedge clk) disable iff (reset)
    access_error |-> ack)
    else $error("error flagged without an answer");

  // segment pins
  a_can_segments: assert property (@(posedge clk) disable iff (reset)
    (periph_bus_global_enable && (periph_enable_register[EN_CAN1]
     || periph_enable_register[EN_CAN2])) |-> segment_lines == 4'h4)
    else $error("segment lines not limited");
  a_full_segments: assert property (@(posedge clk) disable iff (reset)
    !(periph_bus_global_enable && (periph_enable_register[EN_CAN1]
     || periph_enable_register[EN_CAN2])) |-> segment_lines == 4'h8)
    else $error("segment lines limited without can");

  // a low enable must hold every register, window loads included
  a_freeze: assert property (@(posedge clk) disable iff (reset) !clk_en |=> $stable(r))
    else $error("state moved while clock enable low");

  // covers of the main scenarios
  c_periph: cover property (@(posedge clk) r.state == ST_DONE);
  c_ext: cover property (@(posedge clk) ext_cycle);
  c_ram2: cover property (@(posedge clk) ack && target == TGT_RAM2);
  c_boot: cover property (@(posedge clk) ack && target == TGT_TEST);
  c_refused: cover property (@(posedge clk) ack && access_error);
endmodule

// *** sim/oad_cpu_model.sv ***
// partner model: cpu core issuing single byte and word accesses
`timescale 1ns/10ps
module oad_cpu_model (
  // clock and answer
  input  wire logic        clk,
  input  wire logic        ack,
  // request: kind is {write, byte, bit, stack}
  output logic             req,
  output logic [23:0]      addr,
  output logic [3:0]       kind
);
  initial begin
    req = 1'b0;
    addr = 24'h00_0000;
    kind = 4'h0;
  end

  // one-cycle request pulse, qualifiers held until the answer is seen
  task automatic access(input logic [23:0] a, input logic [3:0] k, output bit hung);
    int n;
    @(negedge clk);
    addr = a;
    kind = k;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    hung = (n == 12);
    // released lines change so a stale value cannot pass
    addr = ~a;
    kind = ~k;
  endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the on-chip address decoder
`timescale 1ns/10ps
module testbench
  import oad_pkg::*;
;
  localparam int R2B = RAM2_SMALL_BYTES;
  localparam logic [15:0] PG [8] = '{PAGE_CAN1, PAGE_CAN2, PAGE_RTC, PAGE_PWM,
                                     PAGE_ASC, PAGE_SSC, PAGE_I2C, PAGE_MISC};
  localparam int EB [8] = '{EN_CAN1, EN_CAN2, EN_RTC, EN_PWM, EN_ASC, EN_SSC, EN_I2C, EN_MISC};
  localparam logic [23:0] DA [14] = '{24'h00_0000, 24'h00_7FFE, 24'h00_8000, 24'h01_8000,
    24'h02_FFFE, 24'h03_0000, 24'h04_FFFE, 24'h00_E000, 24'h00_E7FE, 24'h00_E800,
    24'h09_0000, 24'h09_3FFE, 24'h0A_0000, 24'h00_F000};
  localparam logic [23:0] RB [8] = '{24'h00_0000, 24'h01_8000, 24'h00_E000, 24'h00_E800,
    24'h09_0000, 24'h0A_0000, 24'h00_EE00, 24'h20_0000};
  localparam logic [7:0] WS [4] = '{8'h09, 8'h0A, 8'h0B, 8'h10};
  typedef struct {
    logic [8:0]  tgt;
    logic [7:0]  sel;
    logic        err;
    logic [13:0] off;
    logic [23:0] a;
    logic [3:0]  k;
    int          lat;
  } oad_tb_note_t;
  logic         clk, ack, err, xc, req, xw, xb;
  logic         reset = 1'b1, clk_en = 1'b1, gl = 1'b0, boot = 1'b0, wwr = 1'b0;
  logic [15:0]  en = 16'h0000;
  logic [7:0]   wsel = 8'h09, psel, win = 8'h09;
  logic [8:0]   target;
  logic [13:0]  off;
  logic [23:0]  addr, xa, r2w;
  logic [3:0]   kind, seg;
  int           err_total = 0, num_checks = 0, cyc = 0, tk = 0;
  oad_tb_note_t q[$], m;

  oad_decoder #(.RAM2_BYTES(R2B), .PERIPH_WAIT(PERIPH_WAIT_NUM)) uut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .periph_bus_global_enable(gl),
    .periph_enable_register(en), .bootstrap_mode(boot), .window_write(wwr),
    .second_ram_window_select(wsel), .req(req), .addr(addr), .write(kind[3]),
    .byte_access(kind[2]), .bit_access(kind[1]), .stack_access(kind[0]), .ack(ack),
    .access_error(err), .target(target), .periph_select(psel), .ram2_offset(off),
    .ext_cycle(xc), .ext_addr(xa), .ext_write(xw), .ext_byte(xb), .ram2_window(r2w),
    .segment_lines(seg));
  oad_cpu_model cpu (.clk(clk), .ack(ack), .req(req), .addr(addr), .kind(kind));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // cycle count and the edge at which a request was taken
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (req === 1'b1 && clk_en) tk <= cyc;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // note the expected routing, then let the cpu model issue it
  task automatic go(input logic [23:0] a, input logic [3:0] k);
    oad_tb_note_t n;
    bit hung;
    n = '{tgt: TGT_EXT, sel: 8'h00, err: 1'b0, off: a[13:0] & 14'(R2B - 1), a: a, k: k,
          lat: 1};
    if (boot && a <= TEST_SEC_LAST) n.tgt = TGT_TEST;
    else if (a <= FLASH_LOW_LAST || (a >= FLASH_S4_BASE && a <= FLASH_S5_LAST)) n.tgt = TGT_FLASH;
    else if (a >= UPPER_A_BASE && a <= UPPER_B_LAST) n.tgt = TGT_UPPER;
    else if (gl && en[EN_RAM1] && a >= RAM1_BASE && a <= RAM1_LAST) n.tgt = TGT_RAM1;
    else if (gl && en[EN_RAM2] && a[23:16] == win) n.tgt = TGT_RAM2;
    for (int i = 0; i < 8; i++) begin
      if (n.tgt == TGT_EXT && gl && en[EB[i]] && a[23:8] == PG[i]) begin
        n.tgt = TGT_PERIPH;
        n.sel = 8'(1 << i);
        n.err = k[2] | k[1];
        n.lat = n.err ? 1 : PERIPH_WAIT_NUM + 2;
      end
    end
    if (n.tgt inside {TGT_RAM1, TGT_RAM2}) n.err = k[1] | k[0];
    q.push_back(n);
    cpu.access(a, k, hung);
    chk(32'(hung), 32'h0);
  endtask

  task automatic cfg(input logic g, input logic [15:0] e, input logic b);
    @(negedge clk);
    gl = g;
    en = e;
    boot = b;
    @(negedge clk);
    chk(seg, (g && (e[EN_CAN1] || e[EN_CAN2])) ? SEG_LINES_CAN : SEG_LINES_FULL);
  endtask

  task automatic set_win(input logic [7:0] w);
    @(negedge clk);
    wsel = w;
    wwr = 1'b1;
    @(negedge clk);
    wwr = 1'b0;
    win = w;
    chk(r2w, {w, 16'h0000});
  endtask

  task automatic do_reset(input int n);
    @(negedge clk);
    reset = 1'b1;
    repeat (n) @(negedge clk);
    reset = 1'b0;
    win = 8'h09;
    chk(r2w, RAM2_RESET_BASE);
  endtask

  // result watcher: oldest note against each answer
  always @(negedge clk) begin
    if (ack === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        m = q.pop_front();
        chk(err, m.err);
        chk(cyc - tk, m.lat);
        if (!m.err) begin
          chk(target, m.tgt);
          chk(xc, m.tgt == TGT_EXT);
          if (m.tgt == TGT_PERIPH) chk(psel, m.sel);
          if (m.tgt == TGT_RAM1) chk(off, 14'(m.a[10:0]));
          if (m.tgt == TGT_RAM2) chk(off, m.off);
          if (m.tgt == TGT_EXT) chk(xa, m.a);
          if (m.tgt == TGT_EXT) chk(xw, m.k[3]);
          if (m.tgt == TGT_EXT) chk(xb, m.k[2]);
        end
      end
    end
  end

  initial begin
    void'($urandom(32'hb694d56c));
    do_reset(16);
    cfg(1'b1, 16'h07DF, 1'b0);
    foreach (DA[i]) go(DA[i], 4'h0);
    for (int i = 0; i < 8; i++) go({PG[i], 8'h3E}, 4'h8);
    cfg(1'b1, 16'h07DF, 1'b1);
    go(24'h00_0000, 4'h0);
    go(24'h00_1FFE, 4'h0);
    go(24'h00_2000, 4'h0);
    cfg(1'b0, 16'h07DF, 1'b0);
    go(24'h00_E000, 4'h0);
    go(24'h09_0000, 4'h0);
    go(24'h00_EF00, 4'h0);
    cfg(1'b1, 16'h07DF, 1'b0);
    go(24'h00_EF00, 4'h4);
    go(24'h00_ED00, 4'h2);
    go(24'h00_E001, 4'h4);
    go(24'h00_E002, 4'h2);
    go(24'h09_1000, 4'h1);
    set_win(8'h0A);
    go(24'h0A_5234, 4'h0);
    go(24'h09_0000, 4'h0);
    // random traffic keeps clear of the reserved sectors
    for (int i = 0; i < 400; i++) begin
      if (i % 16 == 0) cfg($urandom % 4 != 0, 16'($urandom), $urandom % 4 == 0);
      if (i % 50 == 7) set_win(WS[$urandom % 4]);
      go((RB[$urandom % 8] + 24'($urandom & 32'h7FF)) & 24'hFF_FFFE,
         {1'($urandom), 1'($urandom), $urandom % 8 == 0, $urandom % 8 == 0});
    end
    // a frozen block must ignore a window load
    @(negedge clk);
    clk_en = 1'b0;
    wsel = 8'h0B;
    wwr = 1'b1;
    repeat (3) @(negedge clk);
    chk(r2w, {win, 16'h0000});
    wwr = 1'b0;
    clk_en = 1'b1;
    do_reset(2);
    go(24'h09_2000, 4'h0);
    print_verdict();
  end

  // hang guard, well past the longest expected run
  initial begin
    #400_000;
    err_total++;
    print_verdict();
  end
endmodule
